// ===== hdl/pls_link.sv
// link-side logic of the byte-wide phy-link interface: status, transmit, receive
`timescale 1ns/100ps
`default_nettype none
module pls_link (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    // phy-side pins
    input wire logic [1:0] ctl_i,
    input wire logic [7:0] data_i,
    output logic [1:0] ctl_o,
    output logic ctl_oe_o,
    output logic [7:0] data_o,
    output logic data_oe_o,
    // transmit user side
    input wire logic tx_req_i,
    input wire logic [1:0] tx_speed_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i,
    input wire logic tx_chain_i,
    output logic tx_ready_o,
    output logic tx_done_o,
    output logic tx_speed_err_o,
    // receive user side
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_first_o,
    output logic rx_end_o,
    output logic [1:0] rx_speed_o,
    // status user side
    output logic status_valid_o,
    output logic status_full_o,
    output logic [15:0] status_o,
    output logic arb_gap_o,
    output logic cycle_done_o,
    output logic bus_reset_o,
    output logic phy_int_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_STATUS, ST_RX_ON, ST_RX_DATA, ST_TX_WAIT,
        ST_TX, ST_TX_END, ST_CHAIN} pls_state_e;
    function automatic logic [1:0] decode_speed(input logic [7:0] d);
        if (d[7:6] == 2'h0)
            decode_speed = pls_pkg::SPD_100;
        else if (d[7:4] == pls_pkg::SPD200_CODE)
            decode_speed = pls_pkg::SPD_200;
        else
            decode_speed = pls_pkg::SPD_400;
    endfunction : decode_speed
    pls_state_e st_q, st_d;
    logic [15:0] sh_q, sh_d, stat_q, stat_d, asm_w;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] spd_q, spd_d, rxs_q, rxs_d;
    pls_pkg::pls_pins_s pin_q, pin_d;
    logic tx_on_q, tx_on_d, tx_ready_q, tx_ready_d, tx_done_q, tx_done_d, serr_q, serr_d;
    logic rxv_q, rxv_d, rxf_q, rxf_d, rxe_q, rxe_d, first_q, first_d;
    logic [7:0] rxd_q, rxd_d;
    logic sv_q, sv_d, sf_q, sf_d, arb_q, arb_d, cyc_q, cyc_d, brst_q, brst_d, pint_q, pint_d;
    always_comb
    begin
        st_d = st_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        spd_d = spd_q;
        tx_on_d = tx_on_q;
        pin_d = '{ctl: pls_pkg::LNK_IDLE, data: 8'h00, ctl_oe: 1'b0, data_oe: 1'b0};
        tx_ready_d = 1'b0;
        tx_done_d = 1'b0;
        serr_d = serr_q;
        rxv_d = 1'b0;
        rxf_d = 1'b0;
        rxe_d = 1'b0;
        rxd_d = rxd_q;
        rxs_d = rxs_q;
        first_d = first_q;
        sv_d = 1'b0;
        sf_d = sf_q;
        stat_d = stat_q;
        asm_w = {data_i[1:0], sh_q[15:2]};
        if (tx_req_i && !tx_on_q)
        begin
            tx_on_d = 1'b1;
            spd_d = tx_speed_i;
        end
        case (st_q)
            ST_IDLE:
            begin
                if (ctl_i == pls_pkg::PHY_STATUS)
                begin
                    st_d = ST_STATUS;
                    sh_d = {data_i[1:0], 14'h0000};
                    cnt_d = 4'h1;
                end
                else if (ctl_i == pls_pkg::PHY_RECEIVE)
                    st_d = ST_RX_ON;
                else if (ctl_i == pls_pkg::PHY_GRANT && tx_on_q)
                begin
                    st_d = ST_TX_WAIT;
                    pin_d = '{ctl: pls_pkg::LNK_HOLD, data: 8'h00, ctl_oe: 1'b1, data_oe: 1'b1};
                    tx_ready_d = 1'b1;
                end
            end
            ST_STATUS:
            begin
                if (ctl_i == pls_pkg::PHY_STATUS)
                begin
                    sh_d = asm_w;
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == 4'h7)
                    begin
                        st_d = ST_IDLE;
                        sv_d = 1'b1;
                        sf_d = 1'b1;
                        stat_d = asm_w;
                    end
                end
                else
                begin
                    // a short transfer ends after two cycles; a cut one is dropped and resent
                    st_d = (ctl_i == pls_pkg::PHY_RECEIVE) ? ST_RX_ON : ST_IDLE;
                    if (cnt_q == 4'h2)
                    begin
                        sv_d = 1'b1;
                        sf_d = 1'b0;
                        stat_d = {12'h000, sh_q[15:12]};
                    end
                end
            end
            ST_RX_ON:
            begin
                if (ctl_i != pls_pkg::PHY_RECEIVE)
                    st_d = ST_IDLE;
                else if (data_i != pls_pkg::DATA_ON)
                begin
                    st_d = ST_RX_DATA;
                    rxs_d = decode_speed(data_i);
                    first_d = 1'b1;
                end
            end
            ST_RX_DATA:
            begin
                if (ctl_i == pls_pkg::PHY_RECEIVE)
                begin
                    rxv_d = 1'b1;
                    rxd_d = data_i;
                    rxf_d = first_q;
                    first_d = 1'b0;
                end
                else
                begin
                    st_d = ST_IDLE;
                    rxe_d = 1'b1;
                end
            end
            ST_TX_WAIT, ST_TX:
            begin
                if (tx_valid_i)
                begin
                    pin_d = '{ctl: pls_pkg::LNK_TRANSMIT, data: tx_data_i, ctl_oe: 1'b1, data_oe: 1'b1};
                    st_d = tx_last_i ? ST_TX_END : ST_TX;
                    tx_ready_d = !tx_last_i;
                end
                else
                begin
                    pin_d = '{ctl: (st_q == ST_TX_WAIT) ? pls_pkg::LNK_HOLD : pls_pkg::LNK_TRANSMIT,
                        data: 8'h00, ctl_oe: 1'b1, data_oe: 1'b1};
                    tx_ready_d = 1'b1;
                end
            end
            ST_TX_END:
            begin
                tx_done_d = 1'b1;
                if (tx_chain_i)
                begin
                    st_d = ST_CHAIN;
                    pin_d = '{ctl: pls_pkg::LNK_HOLD, data: 8'h00, ctl_oe: 1'b1, data_oe: 1'b1};
                end
                else
                begin
                    st_d = ST_IDLE;
                    tx_on_d = 1'b0;
                    pin_d = '{ctl: pls_pkg::LNK_IDLE, data: 8'h00, ctl_oe: 1'b1, data_oe: 1'b1};
                end
            end
            ST_CHAIN:
            begin
                // link releases while the transceiver waits before its next grant
                if (ctl_i == pls_pkg::PHY_GRANT)
                begin
                    st_d = ST_TX_WAIT;
                    pin_d = '{ctl: pls_pkg::LNK_HOLD, data: 8'h00, ctl_oe: 1'b1, data_oe: 1'b1};
                    tx_ready_d = 1'b1;
                    if (tx_speed_i != spd_q)
                        serr_d = 1'b1;
                end
                else if (ctl_i == pls_pkg::PHY_RECEIVE)
                    st_d = ST_RX_ON;
            end
            default:
                st_d = ST_IDLE;
        endcase
        arb_d = sv_d & stat_d[pls_pkg::STAT_ARB_GAP];
        cyc_d = sv_d & stat_d[pls_pkg::STAT_FAIR_GAP];
        brst_d = sv_d & stat_d[pls_pkg::STAT_BUS_RESET];
        pint_d = sv_d & stat_d[pls_pkg::STAT_PHY_INT];
    end
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= ST_IDLE;
            sh_q <= 16'h0000;
            cnt_q <= 4'h0;
            spd_q <= 2'h0;
            tx_on_q <= 1'b0;
            pin_q <= '0;
            tx_ready_q <= 1'b0;
            tx_done_q <= 1'b0;
            serr_q <= 1'b0;
            rxv_q <= 1'b0;
            rxf_q <= 1'b0;
            rxe_q <= 1'b0;
            rxd_q <= 8'h00;
            rxs_q <= 2'h0;
            first_q <= 1'b0;
            sv_q <= 1'b0;
            sf_q <= 1'b0;
            stat_q <= 16'h0000;
            arb_q <= 1'b0;
            cyc_q <= 1'b0;
            brst_q <= 1'b0;
            pint_q <= 1'b0;
        end
        else if (en_i)
        begin
            st_q <= st_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            spd_q <= spd_d;
            tx_on_q <= tx_on_d;
            pin_q <= pin_d;
            tx_ready_q <= tx_ready_d;
            tx_done_q <= tx_done_d;
            serr_q <= serr_d;
            rxv_q <= rxv_d;
            rxf_q <= rxf_d;
            rxe_q <= rxe_d;
            rxd_q <= rxd_d;
            rxs_q <= rxs_d;
            first_q <= first_d;
            sv_q <= sv_d;
            sf_q <= sf_d;
            stat_q <= stat_d;
            arb_q <= arb_d;
            cyc_q <= cyc_d;
            brst_q <= brst_d;
            pint_q <= pint_d;
        end
    end
    assign ctl_o = pin_q.ctl;
    assign ctl_oe_o = pin_q.ctl_oe;
    assign data_o = pin_q.data;
    assign data_oe_o = pin_q.data_oe;
    assign tx_ready_o = tx_ready_q;
    assign tx_done_o = tx_done_q;
    assign tx_speed_err_o = serr_q;
    assign rx_valid_o = rxv_q;
    assign rx_data_o = rxd_q;
    assign rx_first_o = rxf_q;
    assign rx_end_o = rxe_q;
    assign rx_speed_o = rxs_q;
    assign status_valid_o = sv_q;
    assign status_full_o = sf_q;
    assign status_o = stat_q;
    assign arb_gap_o = arb_q;
    assign cycle_done_o = cyc_q;
    assign bus_reset_o = brst_q;
    assign phy_int_o = pint_q;
    property p_no_reserved;
        @(posedge clk_i) disable iff (!rst_n_i) ctl_oe_o |-> ctl_o != 2'h3;
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved code driven");
    property p_release;
        @(posedge clk_i) disable iff (!rst_n_i) (ctl_oe_o && ctl_o == pls_pkg::LNK_IDLE) |=> !ctl_oe_o;
    endproperty
    a_release: assert property (p_release) else $error("idle not one cycle");
    property p_oe_pair;
        @(posedge clk_i) disable iff (!rst_n_i) ctl_oe_o == data_oe_o;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("drivers not released together");
    property p_grant;
        @(posedge clk_i) disable iff (!rst_n_i) (en_i && st_q == ST_IDLE && ctl_i == pls_pkg::PHY_GRANT && tx_on_q)
            |=> ctl_oe_o && ctl_o == pls_pkg::LNK_HOLD;
    endproperty
    a_grant: assert property (p_grant) else $error("grant not taken");
    property p_rx_hold;
        @(posedge clk_i) disable iff (!rst_n_i) rx_valid_o |-> !ctl_oe_o;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("driving during receive");
    property p_fair;
        @(posedge clk_i) disable iff (!rst_n_i) cycle_done_o |-> status_valid_o && status_o[pls_pkg::STAT_FAIR_GAP];
    endproperty
    a_fair: assert property (p_fair) else $error("cycle end without status");
    property p_reset_bit;
        @(posedge clk_i) disable iff (!rst_n_i) bus_reset_o |-> status_o[pls_pkg::STAT_BUS_RESET];
    endproperty
    a_reset_bit: assert property (p_reset_bit) else $error("bus reset mismatch");
    property p_short;
        @(posedge clk_i) disable iff (!rst_n_i) (status_valid_o && !status_full_o) |-> status_o[15:4] == 12'h000;
    endproperty
    a_short: assert property (p_short) else $error("short status has upper bits");
    c_status: cover property (@(posedge clk_i) status_valid_o && status_full_o);
    c_rx: cover property (@(posedge clk_i) rx_end_o);
    c_chain: cover property (@(posedge clk_i) st_q == ST_CHAIN);
endmodule : pls_link
`default_nettype wire

// ===== hdl/pls_pkg.sv
// package for the link-side phy interface block
package pls_pkg;
    // control-line codes, transceiver owns the lines
    localparam logic [1:0] PHY_IDLE = 2'h0;
    localparam logic [1:0] PHY_STATUS = 2'h1;
    localparam logic [1:0] PHY_RECEIVE = 2'h2;
    localparam logic [1:0] PHY_GRANT = 2'h3;
    // control-line codes, link owns the lines
    localparam logic [1:0] LNK_IDLE = 2'h0;
    localparam logic [1:0] LNK_HOLD = 2'h1;
    localparam logic [1:0] LNK_TRANSMIT = 2'h2;
    // status stream layout
    localparam int STAT_LEN = 16;
    localparam int STAT_SHORT = 4;
    localparam int STAT_ARB_GAP = 0;
    localparam int STAT_FAIR_GAP = 1;
    localparam int STAT_BUS_RESET = 2;
    localparam int STAT_PHY_INT = 3;
    localparam int STAT_ADDR_LO = 4;
    localparam int STAT_DATA_LO = 8;
    // speed codes reported on rx_speed_o, then the values seen on the data lanes
    localparam logic [1:0] SPD_100 = 2'h0;
    localparam logic [1:0] SPD_200 = 2'h1;
    localparam logic [1:0] SPD_400 = 2'h2;
    localparam logic [7:0] DATA_ON = 8'hff;
    localparam logic [7:0] SPD400_CODE = 8'h50;
    localparam logic [3:0] SPD200_CODE = 4'h4;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] addr;
        logic phy_int;
        logic bus_reset;
        logic fair_gap;
        logic arb_gap;
    } pls_status_s;

    typedef struct packed {
        logic [1:0] ctl;
        logic [7:0] data;
        logic ctl_oe;
        logic data_oe;
    } pls_pins_s;
endpackage : pls_pkg

// ===== verif/pls_phy_model.sv
// behavioural transceiver on the far side of the link interface
`timescale 1ns/100ps
`default_nettype none
module pls_phy_model (
    // clock
    input wire logic clk_i,
    // link drive state
    input wire logic link_oe_i,
    // transceiver drive
    output logic [1:0] ctl_o,
    output logic [7:0] data_o,
    output logic oe_o
);
    initial
    begin
        ctl_o = pls_pkg::PHY_IDLE;
        data_o = 8'h00;
        oe_o = 1'b1;
    end

    task automatic step(input logic [1:0] c, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        ctl_o = c;
        data_o = d;
    endtask : step

    // unused lanes carry a changing pattern the link must ignore
    task automatic status(input logic [15:0] b, input int n);
        for (int k = 0; k < n; k++)
            step(pls_pkg::PHY_STATUS, {6'h2a ^ 6'(k), b[2 * k + 1], b[2 * k]});
        step(pls_pkg::PHY_IDLE, 8'h00);
    endtask : status

    task automatic rx(input logic [7:0] spd, input logic [7:0] base, input int n);
        step(pls_pkg::PHY_RECEIVE, pls_pkg::DATA_ON);
        step(pls_pkg::PHY_RECEIVE, spd);
        for (int k = 0; k < n; k++)
            step(pls_pkg::PHY_RECEIVE, base + 8'(k));
        step(pls_pkg::PHY_IDLE, 8'h00);
    endtask : rx

    // grant after a fixed wait, let go once the link drives, idle after release
    task automatic grant(input int dly);
        int k;
        repeat (dly) @(posedge clk_i);
        step(pls_pkg::PHY_GRANT, 8'h00);
        for (k = 0; k < 20 && !link_oe_i; k++)
        begin
            @(posedge clk_i);
            #1;
        end
        oe_o = 1'b0;
        for (k = 0; k < 100 && link_oe_i; k++)
        begin
            @(posedge clk_i);
            #1;
        end
        ctl_o = pls_pkg::PHY_IDLE;
        oe_o = 1'b1;
    endtask : grant
endmodule : pls_phy_model
`default_nettype wire

// ===== verif/pls_link_tb.sv
// self-checking bench for the link-side transceiver interface
`timescale 1ns/100ps
`default_nettype none
module pls_link_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic en_i = 1'b1;
    logic tx_req_i = 1'b0, tx_valid_i = 1'b0, tx_last_i = 1'b0, tx_chain_i = 1'b0;
    logic [1:0] tx_speed_i = 2'h0;
    logic [7:0] tx_data_i = 8'h00;
    logic [1:0] ctl_o, ctl_w, phy_ctl, rx_speed_o;
    logic [7:0] data_o, data_w, phy_data, rx_data_o;
    logic ctl_oe_o, data_oe_o, phy_oe, tx_ready_o, tx_done_o, tx_speed_err_o, rx_valid_o, rx_first_o, rx_end_o;
    logic status_valid_o, status_full_o, arb_gap_o, cycle_done_o, bus_reset_o, phy_int_o;
    logic [15:0] status_o;
    logic [20:0] st_q;
    logic [7:0] rxq[$], txq[$];
    int mismatches = 0, samples_checked = 0, nst = 0, nfirst = 0, nend = 0;

    always #5 clk_i = ~clk_i;
    // nobody driving: show the inverse of the last link value, not a stale copy
    assign ctl_w = ctl_oe_o ? ctl_o : (phy_oe ? phy_ctl : ~ctl_o);
    assign data_w = data_oe_o ? data_o : (phy_oe ? phy_data : ~data_o);

    pls_link DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .ctl_i(ctl_w), .data_i(data_w),
        .ctl_o(ctl_o), .ctl_oe_o(ctl_oe_o), .data_o(data_o), .data_oe_o(data_oe_o), .tx_req_i(tx_req_i),
        .tx_speed_i(tx_speed_i), .tx_valid_i(tx_valid_i), .tx_data_i(tx_data_i), .tx_last_i(tx_last_i),
        .tx_chain_i(tx_chain_i), .tx_ready_o(tx_ready_o), .tx_done_o(tx_done_o),
        .tx_speed_err_o(tx_speed_err_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
        .rx_first_o(rx_first_o), .rx_end_o(rx_end_o), .rx_speed_o(rx_speed_o),
        .status_valid_o(status_valid_o), .status_full_o(status_full_o), .status_o(status_o),
        .arb_gap_o(arb_gap_o), .cycle_done_o(cycle_done_o), .bus_reset_o(bus_reset_o), .phy_int_o(phy_int_o));

    pls_phy_model PHY (.clk_i(clk_i), .link_oe_i(ctl_oe_o), .ctl_o(phy_ctl), .data_o(phy_data), .oe_o(phy_oe));

    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("MISMATCH at %0t: %s", $time, m);
        end
    endtask : chk

    always @(posedge clk_i)
    begin
        if (status_valid_o === 1'b1)
        begin
            nst++;
            st_q = {status_full_o, arb_gap_o, cycle_done_o, bus_reset_o, phy_int_o, status_o};
        end
        if (rx_valid_o === 1'b1)
            rxq.push_back(rx_data_o);
        if (rx_valid_o === 1'b1 && rx_first_o === 1'b1)
            nfirst++;
        if (rx_end_o === 1'b1)
            nend++;
        if (ctl_oe_o === 1'b1 && ctl_o === pls_pkg::LNK_TRANSMIT)
            txq.push_back(data_o);
        chk(!(ctl_oe_o === 1'b1 && ctl_o === 2'h3), "reserved code");
        chk(!(ctl_oe_o === 1'b1 && phy_oe === 1'b1) && ctl_oe_o === data_oe_o, "contention");
    end

    task automatic st_test(input logic [15:0] b, input int n);
        int n0;
        logic [15:0] m;
        n0 = nst;
        m = (n == 8) ? 16'hffff : 16'h000f;
        PHY.status(b, n);
        repeat (3) @(posedge clk_i);
        #1;
        chk(nst == n0 + 1, "status count");
        chk((st_q[15:0] & m) === (b & m), "status bits");
        chk(st_q[20] === (n == 8), "status length");
        chk(st_q[19:16] === {b[0], b[1], b[2], b[3]}, "status events");
        $display("test status %0d done", n);
    endtask : st_test

    task automatic st_b2b_cut();
        int n0;
        n0 = nst;
        PHY.status(16'h0003, 2);
        PHY.status(16'h5a9c, 8);
        // status cut straight into a receive, with no idle between
        for (int k = 0; k < 4; k++)
            PHY.step(pls_pkg::PHY_STATUS, {6'h00, 2'(16'h1234 >> (2 * k))});
        PHY.rx(8'h00, 8'h11, 2);
        PHY.status(16'h1234, 8);
        repeat (3) @(posedge clk_i);
        #1;
        chk(nst == n0 + 3, "back to back and cut count");
        chk(st_q[15:0] === 16'h1234, "retried status");
        $display("test status b2b cut done");
    endtask : st_b2b_cut

    task automatic en_test();
        int n0;
        n0 = nst;
        en_i = 1'b0;
        PHY.status(16'h000f, 2);
        repeat (3) @(posedge clk_i);
        #1;
        chk(nst == n0, "status taken while disabled");
        en_i = 1'b1;
        $display("test enable done");
    endtask : en_test

    task automatic rx_test(input logic [7:0] code, input logic [1:0] exp);
        int f0, e0;
        f0 = nfirst;
        e0 = nend;
        rxq.delete();
        PHY.rx(code, 8'ha0, 3);
        repeat (3) @(posedge clk_i);
        #1;
        chk(rxq.size() == 3, "rx byte count");
        for (int k = 0; k < 3 && k < rxq.size(); k++)
            chk(rxq[k] === 8'ha0 + 8'(k), "rx byte");
        chk(rx_speed_o === exp, "rx speed");
        chk(nfirst == f0 + 1 && nend == e0 + 1, "rx framing");
        $display("test rx speed %0d done", exp);
    endtask : rx_test

    task automatic tx_pkt(input int n, input logic chain, input logic [1:0] spd);
        int k;
        txq.delete();
        tx_req_i = 1'b1;
        tx_speed_i = spd;
        tx_chain_i = chain;
        fork
            PHY.grant(4);
            begin
                for (k = 0; k < 40 && tx_ready_o !== 1'b1; k++)
                begin
                    @(posedge clk_i);
                    #1;
                end
                chk(ctl_o === pls_pkg::LNK_HOLD && ctl_oe_o === 1'b1, "hold on grant");
                repeat (2) @(posedge clk_i);
                #1;
                chk(ctl_o === pls_pkg::LNK_HOLD, "hold while not ready");
                for (k = 0; k < n; k++)
                begin
                    tx_valid_i = 1'b1;
                    tx_data_i = 8'hc0 + 8'(k);
                    tx_last_i = (k == n - 1);
                    @(posedge clk_i);
                    #1;
                end
                tx_valid_i = 1'b0;
                tx_last_i = 1'b0;
                for (k = 0; k < 10 && tx_done_o !== 1'b1; k++)
                begin
                    @(posedge clk_i);
                    #1;
                end
                chk(ctl_o === (chain ? pls_pkg::LNK_HOLD : pls_pkg::LNK_IDLE) && ctl_oe_o === 1'b1, "end");
                if (!chain)
                    tx_req_i = 1'b0;
                @(posedge clk_i);
                #1;
                chk(ctl_oe_o === 1'b0, "release");
            end
        join
        chk(txq.size() == n, "tx byte count");
        for (k = 0; k < n && k < txq.size(); k++)
            chk(txq[k] === 8'hc0 + 8'(k), "tx byte");
        $display("test tx %0d bytes done", n);
    endtask : tx_pkt

    task automatic close_out();
        $display("checked %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out

    initial
    begin
        repeat (10) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        st_test(16'h0005, 2);
        st_test(16'h000a, 2);
        st_test(16'hc37a, 8);
        en_test();
        st_b2b_cut();
        rx_test(8'h00, pls_pkg::SPD_100);
        rx_test(8'h40, pls_pkg::SPD_200);
        rx_test(8'h50, pls_pkg::SPD_400);
        tx_pkt(3, 1'b1, pls_pkg::SPD_400);
        chk(tx_speed_err_o === 1'b0, "speed error early");
        tx_pkt(1, 1'b1, pls_pkg::SPD_400);
        tx_pkt(2, 1'b0, pls_pkg::SPD_200);
        chk(tx_speed_err_o === 1'b1, "speed error");
        close_out();
    end

    initial
    begin
        #20000;
        mismatches++;
        close_out();
    end
endmodule : pls_link_tb
`default_nettype wire
